// >>> design/serp_pkg.sv
package serp_pkg;
   // register select codes for the command port
   typedef enum logic [3:0] {
      SERP_REG_SRE,
      SERP_REG_STB,
      SERP_REG_STDEV,
      SERP_REG_ESE,
      SERP_REG_OP_COND,
      SERP_REG_OP_PTR,
      SERP_REG_OP_NTR,
      SERP_REG_OP_EVENT,
      SERP_REG_OP_ENABLE,
      SERP_REG_QU_COND,
      SERP_REG_QU_PTR,
      SERP_REG_QU_NTR,
      SERP_REG_QU_EVENT,
      SERP_REG_QU_ENABLE
   } serp_reg_type;

   // standard event bit positions
   localparam int SERP_SEV_OPC = 0;
   localparam int SERP_SEV_QUERY = 2;
   localparam int SERP_SEV_DEVICE = 3;
   localparam int SERP_SEV_EXEC = 4;
   localparam int SERP_SEV_CMD = 5;
   localparam int SERP_SEV_PON = 7;

   // status byte bit positions
   localparam int SERP_STB_QUEST = 3;
   localparam int SERP_STB_MAV = 4;
   localparam int SERP_STB_STD = 5;
   localparam int SERP_STB_MASTER = 6;
   localparam int SERP_STB_OPER = 7;

   // group width and defaults loaded by preset and power-on
   localparam int SERP_GRP_W = 16;
   localparam logic [15:0] SERP_PTR_DEFAULT = 16'h7fff;
   localparam logic [15:0] SERP_NTR_DEFAULT = 16'h0000;
   localparam logic [15:0] SERP_MASK_CLEAR = 16'h0000;
   localparam logic [7:0] SERP_BYTE_CLEAR = 8'h00;
   // bit 15 always reads zero
   localparam logic [15:0] SERP_GRP_VALID = 16'h7fff;

   // pending-operation tracking states
   typedef enum logic [1:0] {
      SERP_OPC_IDLE,
      SERP_OPC_WAIT
   } serp_opc_type;
endpackage

// >>> design/serp_group.sv
`timescale 1ns/1ps
// one condition group: filters, sticky events, enable, summary
module serp_group
   import serp_pkg::*;
#(
   parameter int W = SERP_GRP_W
)(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // live status
   input wire logic [W-1:0] cond_in,
   input wire logic [W-1:0] event_in,
   // control
   input wire logic preset,
   input wire logic clear_status,
   input wire logic wr_ptr,
   input wire logic wr_ntr,
   input wire logic wr_enable,
   input wire logic rd_event,
   input wire logic [W-1:0] wr_data,
   // state
   output logic [W-1:0] cond_q,
   output logic [W-1:0] ptr_q,
   output logic [W-1:0] ntr_q,
   output logic [W-1:0] event_q,
   output logic [W-1:0] enable_q,
   output logic summary_q
);
   logic [W-1:0] set_d;
   logic [W-1:0] event_d;

   always_ff @(posedge clk)
   begin
      if (!resetn)
         cond_q <= '0;
      else
         cond_q <= cond_in & W'(SERP_GRP_VALID);
   end

   always_ff @(posedge clk)
   begin
      if (!resetn || preset)
      begin
         ptr_q <= W'(SERP_PTR_DEFAULT);
         ntr_q <= W'(SERP_NTR_DEFAULT);
      end
      else
      begin
         if (wr_ptr)
            ptr_q <= wr_data & W'(SERP_GRP_VALID);
         if (wr_ntr)
            ntr_q <= wr_data & W'(SERP_GRP_VALID);
      end
   end

   always_ff @(posedge clk)
   begin
      if (!resetn || preset)
         enable_q <= W'(SERP_MASK_CLEAR);
      else if (wr_enable)
         enable_q <= wr_data & W'(SERP_GRP_VALID);
   end

   always_comb
   begin
      set_d = (ptr_q & cond_in & ~cond_q) | (ntr_q & ~cond_in & cond_q);
      set_d = (set_d | event_in) & W'(SERP_GRP_VALID);
   end

   always_comb
   begin
      event_d = (rd_event || clear_status) ? set_d : (event_q | set_d);
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
         event_q <= '0;
      else
         event_q <= event_d;
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
         summary_q <= 1'b0;
      else
         summary_q <= |(event_d & enable_q);
   end

   // rising edge with positive filter sets event
   AST_RISE_SETS: assert property (@(posedge clk) disable iff (!resetn)
      (|(ptr_q & cond_in & ~cond_q)) |=> (|event_q))
      else $error("rising edge did not set event");
   AST_STICKY: assert property (@(posedge clk) disable iff (!resetn)
      (event_q[0] && !rd_event && !clear_status) |=> event_q[0])
      else $error("event bit dropped without read");
endmodule // serp_group

// >>> design/serp_status.sv
`timescale 1ns/1ps
// Behaviour
// - service enable mask selects status byte bits
// - zero mask means no request; reset clears
// - no pending: operation-complete sets bit 0
// - pending: set bit 0 on falling pending
// - single/continuous measurement drives pending condition
// - block mode pending until last measurement
// - query error sets event bit 2
// - device error sets event bit 3
// - execution error sets event bit 4
// - command error sets event bit 5
// - power-on sets event bit 7
// - bits 1 and 6 never set
// - event enable mask drives status bit 5
// - two groups with full register sets
// - conditions track live status, reads harmless
// - filters choose which edges set events
// - filters kept on clear, defaulted on preset
// - event bits sticky until read
// - query or clear-status clears event registers
// - group enable masks select summary bits
// - summaries at status bits 3,5,6,7
module serp_status
   import serp_pkg::*;
#(
   parameter int W = SERP_GRP_W
)(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // register command port from the command parser
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire serp_reg_type reg_sel,
   input wire logic [W-1:0] reg_wdata,
   output logic [W-1:0] reg_rdata_q,
   output logic reg_rvalid_q,
   // commands
   input wire logic cmd_clear_status,
   input wire logic cmd_preset,
   input wire logic cmd_opc,
   // measurement activity
   input wire logic meas_start,
   input wire logic meas_end,
   input wire logic block_mode,
   input wire logic block_last_done,
   // error class events
   input wire logic err_query,
   input wire logic err_device,
   input wire logic err_exec,
   input wire logic err_cmd,
   // queue and live status
   input wire logic msg_available,
   input wire logic [W-1:0] oper_cond_in,
   input wire logic [W-1:0] oper_event_in,
   input wire logic [W-1:0] quest_cond_in,
   input wire logic [W-1:0] quest_event_in,
   // summaries
   output logic [7:0] status_byte_q,
   output logic service_request_q,
   output logic pending_q
);
   logic [7:0] sre_q;
   logic [7:0] ese_q;
   logic [7:0] standard_event_latch;
   logic [7:0] std_set;
   logic pon_done_q;
   logic pend_fall;
   logic opc_fire;
   logic std_event_summary;
   logic questionable_summary;
   logic operation_summary;
   logic master_summary;
   logic [7:0] stb_d;
   serp_opc_type opc_q;
   logic [W-1:0] op_cond, op_ptr, op_ntr, op_event, op_enable;
   logic [W-1:0] qu_cond, qu_ptr, qu_ntr, qu_event, qu_enable;
   logic op_sum_q;
   logic qu_sum_q;

   function automatic logic is_sel(input serp_reg_type s, input serp_reg_type t);
      is_sel = (s == t);
   endfunction

   // ----------------------------------------------------------------
   // condition groups
   // ----------------------------------------------------------------
   // operation group
   serp_group #(.W(W)) u_oper (
      .clk(clk),
      .resetn(resetn),
      .cond_in(oper_cond_in),
      .event_in(oper_event_in),
      .preset(cmd_preset),
      .clear_status(cmd_clear_status),
      .wr_ptr(reg_wr && is_sel(reg_sel, SERP_REG_OP_PTR)),
      .wr_ntr(reg_wr && is_sel(reg_sel, SERP_REG_OP_NTR)),
      .wr_enable(reg_wr && is_sel(reg_sel, SERP_REG_OP_ENABLE)),
      .rd_event(reg_rd && is_sel(reg_sel, SERP_REG_OP_EVENT)),
      .wr_data(reg_wdata),
      .cond_q(op_cond),
      .ptr_q(op_ptr),
      .ntr_q(op_ntr),
      .event_q(op_event),
      .enable_q(op_enable),
      .summary_q(op_sum_q)
   );

   serp_group #(.W(W)) u_quest (
      .clk(clk),
      .resetn(resetn),
      .cond_in(quest_cond_in),
      .event_in(quest_event_in),
      .preset(cmd_preset),
      .clear_status(cmd_clear_status),
      .wr_ptr(reg_wr && is_sel(reg_sel, SERP_REG_QU_PTR)),
      .wr_ntr(reg_wr && is_sel(reg_sel, SERP_REG_QU_NTR)),
      .wr_enable(reg_wr && is_sel(reg_sel, SERP_REG_QU_ENABLE)),
      .rd_event(reg_rd && is_sel(reg_sel, SERP_REG_QU_EVENT)),
      .wr_data(reg_wdata),
      .cond_q(qu_cond),
      .ptr_q(qu_ptr),
      .ntr_q(qu_ntr),
      .event_q(qu_event),
      .enable_q(qu_enable),
      .summary_q(qu_sum_q)
   );

   // ----------------------------------------------------------------
   // pending operation
   // ----------------------------------------------------------------
   // pending rises at start; block mode ends on last
   always_ff @(posedge clk)
   begin
      if (!resetn)
         pending_q <= 1'b0;
      else if (meas_start)
         pending_q <= 1'b1;
      else if (block_mode ? block_last_done : meas_end)
         pending_q <= 1'b0;
   end

   assign pend_fall = pending_q && !meas_start && (block_mode ? block_last_done : meas_end);

   always_ff @(posedge clk)
   begin
      if (!resetn)
         opc_q <= SERP_OPC_IDLE;
      else
         case (opc_q)
            SERP_OPC_IDLE:
               if (cmd_opc && pending_q && !pend_fall)
                  opc_q <= SERP_OPC_WAIT;
            SERP_OPC_WAIT:
               if (pend_fall)
                  opc_q <= SERP_OPC_IDLE;
            default:
               opc_q <= SERP_OPC_IDLE;
         endcase
   end

   assign opc_fire = (cmd_opc && (!pending_q || pend_fall))
      || (opc_q == SERP_OPC_WAIT && pend_fall);

   // ----------------------------------------------------------------
   // standard event register
   // ----------------------------------------------------------------
   // power-on flag: the first cycle after reset is the supply event
   always_ff @(posedge clk)
   begin
      if (!resetn)
         pon_done_q <= 1'b0;
      else
         pon_done_q <= 1'b1;
   end

   always_comb
   begin
      std_set = SERP_BYTE_CLEAR;
      std_set[SERP_SEV_OPC] = opc_fire;
      std_set[SERP_SEV_QUERY] = err_query;
      std_set[SERP_SEV_DEVICE] = err_device;
      std_set[SERP_SEV_EXEC] = err_exec;
      std_set[SERP_SEV_CMD] = err_cmd;
      std_set[SERP_SEV_PON] = !pon_done_q;
      // bits 1 and 6 stay clear by construction
   end

   // read or clear-status empties it, set wins
   always_ff @(posedge clk)
   begin
      if (!resetn)
         standard_event_latch <= SERP_BYTE_CLEAR;
      else if (cmd_clear_status || (reg_rd && is_sel(reg_sel, SERP_REG_STDEV)))
         standard_event_latch <= std_set;
      else
         standard_event_latch <= standard_event_latch | std_set;
   end

   // ----------------------------------------------------------------
   // enable masks
   // ----------------------------------------------------------------
   // both masks clear at reset
   always_ff @(posedge clk)
   begin
      if (!resetn)
         sre_q <= SERP_BYTE_CLEAR;
      else if (reg_wr && is_sel(reg_sel, SERP_REG_SRE))
         sre_q <= reg_wdata[7:0];
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
         ese_q <= SERP_BYTE_CLEAR;
      else if (reg_wr && is_sel(reg_sel, SERP_REG_ESE))
         ese_q <= reg_wdata[7:0];
   end

   // ----------------------------------------------------------------
   // status byte and service request
   // ----------------------------------------------------------------
   // standard summary from enabled events
   assign std_event_summary = |(standard_event_latch & ese_q);
   assign questionable_summary = qu_sum_q;
   assign operation_summary = op_sum_q;

   always_comb
   begin
      stb_d = SERP_BYTE_CLEAR;
      stb_d[SERP_STB_QUEST] = questionable_summary;
      stb_d[SERP_STB_MAV] = msg_available;
      stb_d[SERP_STB_STD] = std_event_summary;
      stb_d[SERP_STB_OPER] = operation_summary;
      // request from enabled bits, bit 6 excluded
      master_summary = |(stb_d & sre_q);
      stb_d[SERP_STB_MASTER] = master_summary;
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         status_byte_q <= SERP_BYTE_CLEAR;
         service_request_q <= 1'b0;
      end
      else
      begin
         status_byte_q <= stb_d;
         service_request_q <= master_summary;
      end
   end

   // ----------------------------------------------------------------
   // register reads
   // ----------------------------------------------------------------
   // condition reads have no side effect
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         reg_rdata_q <= '0;
         reg_rvalid_q <= 1'b0;
      end
      else
      begin
         reg_rvalid_q <= reg_rd;
         if (reg_rd)
            case (reg_sel)
               SERP_REG_SRE: reg_rdata_q <= W'(sre_q);
               SERP_REG_STB: reg_rdata_q <= W'(stb_d);
               SERP_REG_STDEV: reg_rdata_q <= W'(standard_event_latch);
               SERP_REG_ESE: reg_rdata_q <= W'(ese_q);
               SERP_REG_OP_COND: reg_rdata_q <= op_cond;
               SERP_REG_OP_PTR: reg_rdata_q <= op_ptr;
               SERP_REG_OP_NTR: reg_rdata_q <= op_ntr;
               SERP_REG_OP_EVENT: reg_rdata_q <= op_event;
               SERP_REG_OP_ENABLE: reg_rdata_q <= op_enable;
               SERP_REG_QU_COND: reg_rdata_q <= qu_cond;
               SERP_REG_QU_PTR: reg_rdata_q <= qu_ptr;
               SERP_REG_QU_NTR: reg_rdata_q <= qu_ntr;
               SERP_REG_QU_EVENT: reg_rdata_q <= qu_event;
               SERP_REG_QU_ENABLE: reg_rdata_q <= qu_enable;
               default: reg_rdata_q <= '0;
            endcase
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   AST_SRE_ZERO: assert property (@(posedge clk) disable iff (!resetn)
      (sre_q == 8'h00) |=> !service_request_q)
      else $error("service request with zero mask");
   AST_OPC_IMMEDIATE: assert property (@(posedge clk) disable iff (!resetn)
      (cmd_opc && !pending_q) |=> standard_event_latch[SERP_SEV_OPC])
      else $error("operation complete not set immediately");
   AST_OPC_WAIT: assert property (@(posedge clk) disable iff (!resetn)
      (opc_q == SERP_OPC_WAIT && pend_fall) |=> standard_event_latch[SERP_SEV_OPC])
      else $error("operation complete missed falling pending");
   AST_PEND_RISE: assert property (@(posedge clk) disable iff (!resetn)
      meas_start |=> pending_q)
      else $error("pending not raised at start");
   AST_BLOCK_HOLD: assert property (@(posedge clk) disable iff (!resetn)
      (pending_q && block_mode && !block_last_done) |=> pending_q)
      else $error("pending dropped inside block");
   AST_QUERY_ERR: assert property (@(posedge clk) disable iff (!resetn)
      err_query |=> standard_event_latch[SERP_SEV_QUERY])
      else $error("query error not latched");
   AST_DEVICE_ERR: assert property (@(posedge clk) disable iff (!resetn)
      err_device |=> standard_event_latch[SERP_SEV_DEVICE])
      else $error("device error not latched");
   AST_EXEC_ERR: assert property (@(posedge clk) disable iff (!resetn)
      err_exec |=> standard_event_latch[SERP_SEV_EXEC])
      else $error("execution error not latched");
   AST_CMD_ERR: assert property (@(posedge clk) disable iff (!resetn)
      err_cmd |=> standard_event_latch[SERP_SEV_CMD])
      else $error("command error not latched");
   AST_UNUSED_BITS: assert property (@(posedge clk) disable iff (!resetn)
      (standard_event_latch[1] == 1'b0) && (standard_event_latch[6] == 1'b0))
      else $error("unused standard event bit set");
   AST_READ_KEEPS_NEW: assert property (@(posedge clk) disable iff (!resetn)
      (reg_rd && reg_sel == SERP_REG_STDEV && err_cmd) |=> standard_event_latch[SERP_SEV_CMD])
      else $error("event lost during read");
   AST_CLEAR_STD: assert property (@(posedge clk) disable iff (!resetn)
      (cmd_clear_status && std_set == SERP_BYTE_CLEAR)
      |=> (standard_event_latch == SERP_BYTE_CLEAR))
      else $error("clear status left standard events");
   AST_SRQ_RAISE: assert property (@(posedge clk) disable iff (!resetn)
      (|({operation_summary, 1'b0, std_event_summary, msg_available, questionable_summary,
         3'b000} & sre_q)) |=> service_request_q)
      else $error("enabled summary raised no request");
   AST_STD_SUMMARY: assert property (@(posedge clk) disable iff (!resetn)
      (|(standard_event_latch & ese_q)) |=> status_byte_q[SERP_STB_STD])
      else $error("standard summary missing");
endmodule // serp_status

// >>> verification/serp_host.sv
`timescale 1ns/1ps
// remote controller issuing register commands to the status block
module serp_host
   import serp_pkg::*;
(
   // clock
   input wire logic clk,
   // command side
   output logic reg_wr,
   output logic reg_rd,
   output serp_reg_type reg_sel,
   output logic [15:0] reg_wdata,
   // answer side
   input wire logic [15:0] reg_rdata_q,
   input wire logic reg_rvalid_q
);
   initial
   begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_sel = SERP_REG_SRE;
      reg_wdata = 16'h0000;
   end

   task automatic write(input serp_reg_type s, input logic [15:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_sel <= s;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      // released data must not look like a valid word
      reg_wdata <= ~d;
   endtask

   task automatic read(input serp_reg_type s, output logic [15:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_sel <= s;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      d = reg_rvalid_q ? reg_rdata_q : 16'hxxxx;
   endtask
endmodule // serp_host

// >>> verification/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, e, s) \
   begin \
      n_compared++; \
      if ((s) !== (e)) \
      begin \
         mismatches++; \
         $display("MISMATCH %s expected %h seen %h", nm, e, s); \
      end \
   end
module testbench
   import serp_pkg::*;
;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [9:0] pl = 10'h000;
   logic block_mode = 1'b0;
   logic msg_available = 1'b0;
   logic [15:0] cond_drv [2] = '{default: 16'h0000};
   logic [15:0] ev_drv [2] = '{default: 16'h0000};
   logic [15:0] cur [2] = '{default: 16'h0000};
   logic reg_wr, reg_rd, reg_rvalid_q, service_request_q, pending_q;
   serp_reg_type reg_sel;
   logic [15:0] reg_wdata, reg_rdata_q, rd, ptr, ntr, en, ev, nw, ei;
   logic [7:0] status_byte_q;
   int mismatches = 0;
   int n_compared = 0;
   int cycles = 0;
   int bs;

   always #5 clk = ~clk;

   // ------------------------------------------------------------
   // design and controller
   // ------------------------------------------------------------
   serp_status u_serp_status (
      .clk(clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_sel(reg_sel), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
      .reg_rvalid_q(reg_rvalid_q), .cmd_clear_status(pl[0]), .cmd_preset(pl[1]),
      .cmd_opc(pl[2]), .meas_start(pl[3]), .meas_end(pl[4]), .block_mode(block_mode),
      .block_last_done(pl[5]), .err_query(pl[6]), .err_device(pl[7]),
      .err_exec(pl[8]), .err_cmd(pl[9]), .msg_available(msg_available),
      .oper_cond_in(cond_drv[0]), .oper_event_in(ev_drv[0]),
      .quest_cond_in(cond_drv[1]), .quest_event_in(ev_drv[1]),
      .status_byte_q(status_byte_q), .service_request_q(service_request_q),
      .pending_q(pending_q)
   );

   serp_host u_serp_host (
      .clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_sel(reg_sel),
      .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q)
   );

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic results();
      if (mismatches == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic pulse(input int i);
      @(posedge clk);
      pl[i] <= 1'b1;
      @(posedge clk);
      pl[i] <= 1'b0;
   endtask

   // ends just after an edge so outputs have settled
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic rchk(input serp_reg_type s, input logic [15:0] e, input string nm);
      u_serp_host.read(s, rd);
      `CHK(nm, e, rd)
   endtask

   function automatic logic [15:0] edge_ev(input logic [15:0] p, n, pt, nt);
      return (~p & n & pt) | (p & ~n & nt);
   endfunction

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         results();
      end
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      void'($urandom(1));
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      idle(3);
      rchk(SERP_REG_SRE, 16'h0000, "sre reset");
      rchk(SERP_REG_ESE, 16'h0000, "ese reset");
      rchk(SERP_REG_OP_PTR, SERP_PTR_DEFAULT, "ptr reset");
      rchk(SERP_REG_QU_NTR, SERP_NTR_DEFAULT, "ntr reset");
      rchk(SERP_REG_QU_ENABLE, 16'h0000, "enable reset");
      rchk(SERP_REG_STDEV, 16'h0080, "power on");
      rchk(SERP_REG_STDEV, 16'h0000, "std read clear");
      for (int b = 0; b < 4; b++)
      begin
         pulse(6 + b);
         idle(2);
         rchk(SERP_REG_STDEV, 16'h0001 << (b + 2), "error class");
      end
      // an event in the cycle of the read survives the read
      fork
         u_serp_host.read(SERP_REG_STDEV, rd);
         pulse(9);
      join
      `CHK("read old", 16'h0000, rd)
      rchk(SERP_REG_STDEV, 16'h0020, "kept event");
      pulse(2);
      idle(2);
      rchk(SERP_REG_STDEV, 16'h0001, "opc idle");
      pulse(3);
      idle(2);
      `CHK("pending", 1'b1, pending_q)
      pulse(2);
      idle(2);
      rchk(SERP_REG_STDEV, 16'h0000, "opc early");
      pulse(4);
      idle(2);
      `CHK("pending end", 1'b0, pending_q)
      rchk(SERP_REG_STDEV, 16'h0001, "opc late");
      @(posedge clk);
      block_mode <= 1'b1;
      pulse(3);
      pulse(4);
      idle(2);
      `CHK("block pending", 1'b1, pending_q)
      pulse(5);
      idle(2);
      `CHK("block done", 1'b0, pending_q)
      @(posedge clk);
      block_mode <= 1'b0;
      u_serp_host.write(SERP_REG_ESE, 16'h0004);
      pulse(6);
      idle(4);
      `CHK("std summary", 1'b1, status_byte_q[SERP_STB_STD])
      `CHK("no request", 1'b0, service_request_q)
      u_serp_host.write(SERP_REG_SRE, 16'h0020);
      idle(4);
      `CHK("request", 1'b1, service_request_q)
      `CHK("master", 1'b1, status_byte_q[SERP_STB_MASTER])
      rchk(SERP_REG_STDEV, 16'h0004, "std events");
      @(posedge clk);
      msg_available <= 1'b1;
      idle(4);
      // message bit shows but is not enabled for a request
      `CHK("masked", 3'b100, {status_byte_q[SERP_STB_MAV], status_byte_q[SERP_STB_STD], service_request_q})
      @(posedge clk);
      msg_available <= 1'b0;
      // random filters, conditions and direct events in both groups
      for (int g = 0; g < 2; g++)
      begin
         bs = g ? int'(SERP_REG_QU_COND) : int'(SERP_REG_OP_COND);
         for (int it = 0; it < 6; it++)
         begin
            ptr = 16'($urandom) & SERP_GRP_VALID;
            ntr = 16'($urandom) & SERP_GRP_VALID;
            en = 16'($urandom) & SERP_GRP_VALID;
            u_serp_host.write(serp_reg_type'(bs + 1), ptr);
            u_serp_host.write(serp_reg_type'(bs + 2), ntr);
            u_serp_host.write(serp_reg_type'(bs + 4), en);
            u_serp_host.read(serp_reg_type'(bs + 3), rd);
            ev = 16'h0000;
            repeat (4)
            begin
               nw = 16'($urandom) & SERP_GRP_VALID;
               ei = 16'($urandom) & SERP_GRP_VALID;
               @(posedge clk);
               cond_drv[g] <= nw;
               ev_drv[g] <= ei;
               @(posedge clk);
               ev_drv[g] <= 16'h0000;
               idle(2);
               ev |= edge_ev(cur[g], nw, ptr, ntr) | ei;
               cur[g] = nw;
            end
            idle(2);
            `CHK("group summary", |(ev & en), status_byte_q[g ? SERP_STB_QUEST : SERP_STB_OPER])
            rchk(serp_reg_type'(bs), cur[g], "condition");
            rchk(serp_reg_type'(bs), cur[g], "condition again");
            rchk(serp_reg_type'(bs + 3), ev, "event");
            rchk(serp_reg_type'(bs + 3), 16'h0000, "event cleared");
         end
      end
      // clear-status empties events but keeps filters
      u_serp_host.write(SERP_REG_OP_PTR, 16'h0f0f);
      u_serp_host.write(SERP_REG_OP_ENABLE, 16'h0f0f);
      @(posedge clk);
      cond_drv[0] <= 16'h0000;
      idle(3);
      @(posedge clk);
      cond_drv[0] <= 16'h0f0f;
      idle(4);
      `CHK("oper summary", 1'b1, status_byte_q[SERP_STB_OPER])
      pulse(9);
      pulse(0);
      idle(3);
      `CHK("summary cleared", 1'b0, status_byte_q[SERP_STB_OPER])
      rchk(SERP_REG_OP_EVENT, 16'h0000, "clear status");
      rchk(SERP_REG_STDEV, 16'h0000, "std clear status");
      rchk(SERP_REG_OP_PTR, 16'h0f0f, "ptr kept");
      pulse(1);
      idle(2);
      rchk(SERP_REG_OP_PTR, SERP_PTR_DEFAULT, "ptr preset");
      rchk(SERP_REG_OP_NTR, SERP_NTR_DEFAULT, "ntr preset");
      rchk(SERP_REG_OP_ENABLE, 16'h0000, "enable preset");
      results();
   end
endmodule // testbench
